// [flash_write_protection.sv]
// Write-protection logic of a serial flash: status and function bytes, pin muxing
`include "fwp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module flash_write_protection
    import fwp_pkg::*;
#(
    parameter logic RST_DIS_DEFAULT = 1'b0
)
(
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone classic slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [4:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic             wbAck,
    output logic [31:0]      wbDatR,
    // Link side: decoded commands on the serial clock
    input  wire logic        serialClk,
    input  wire logic        cmdStrobe,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [25:0] cmdAddr,
    input  wire logic [7:0]  cmdData,
    // Shared pins: write-protect or IO2, hold or IO3
    input  wire logic [1:0]  sharedPinIn,
    output logic      [1:0]  sharedPinOut,
    output logic      [1:0]  sharedPinOe,
    // Quad data path toward the rest of the device
    input  wire logic [1:0]  quadDataOut,
    input  wire logic [1:0]  quadDriveEn,
    output logic      [1:0]  quadDataIn,
    output logic             holdAsserted,
    // Array engine
    input  wire logic        arrayBusy,
    output logic             arrayOpStart,
    output logic             arrayOpErase,
    output logic      [25:0] arrayOpAddr,
    output logic             opRefused
);

    // Link-domain capture
    logic        linkToggleReg;
    logic [7:0]  linkCodeReg;
    logic [25:0] linkAddrReg;
    logic [7:0]  linkDataReg;

    // System-domain state
    logic [`SYNC_W-1:0] syncStable;
    logic               togglePrevReg;
    logic               newCmd;
    cmd_class_t         cmdCls;
    logic               wrLatchReg;
    logic [5:0]         statusBitsReg;
    logic [7:0]         funcReg;
    logic [7:0]         readParamsReg;
    logic [7:0]         bankAddrReg;
    logic [7:0]         refusedCountReg;
    logic               map256Reg;
    logic               quadOn;
    logic               statusLocked;
    logic               targetHit;
    logic               isArrayErase;
    logic               bpAllZero;
    logic               opAllowed;
    logic               opBlocked;
    logic               busReq;
    logic               busWrite;
    bp_level_t          bpLevel;

    // Sort an opcode into the class of work it asks for
    function automatic cmd_class_t classify(input logic [7:0] code);
        cmd_class_t c;
        c = CLS_IGNORE;
        unique case (code)
            `OP_WR_ENABLE, `OP_WR_DISABLE:             c = CLS_LATCH;
            `OP_STATUS_WR:                             c = CLS_STATUS;
            `OP_FUNC_WR:                               c = CLS_FUNC;
            `OP_RDPARAM_VOL_FREE, `OP_RDPARAM_VOL,
            `OP_BANK_VOL_FREE, `OP_BANK_VOL:           c = CLS_VOLREG;
            `OP_PAGE_PROG, `OP_PAGE_PROG4, `OP_SECT_ERASE,
            `OP_SECT_ERASE_ALT, `OP_BLOCK_ERASE,
            `OP_ARRAY_ERASE, `OP_ARRAY_ERASE_ALT:      c = CLS_ARRAY;
            `OP_SUSPEND, `OP_RESUME:                   c = CLS_SUSPEND;
            default:                                   c = CLS_IGNORE;
        endcase
        return c;
    endfunction

    // Register read mux; unmapped offsets read as zero
    function automatic logic [31:0] readMux(input logic [4:0] adr);
        logic [31:0] d;
        d = `DATA_ZERO;
        case ({adr[4:2], `WORD_PAD})
            `REG_STATUS:  d = {24'h00_0000, statusBitsReg, wrLatchReg, arrayBusy};
            `REG_FUNC:    d = {24'h00_0000, funcReg};
            `REG_CTRL:    d = {31'h0000_0000, map256Reg};
            `REG_PARAMS:  d = {16'h0000, bankAddrReg, readParamsReg};
            `REG_REFUSED: d = {24'h00_0000, refusedCountReg};
            default:      d = `DATA_ZERO;
        endcase
        return d;
    endfunction

    // Link domain: a toggle flips per command; words hold until the next strobe
    // so the system side may read them once the toggle has crossed
    always_ff @(posedge serialClk) begin
        if (rst) begin
            linkToggleReg <= 1'b0;
        end else if (cmdStrobe) begin
            linkToggleReg <= ~linkToggleReg;
        end
    end

    // Command words, captured with the strobe
    always_ff @(posedge serialClk) begin
        if (rst) begin
            linkCodeReg <= `OP_WR_DISABLE;
            linkAddrReg <= 26'h000_0000;
            linkDataReg <= 8'h00;
        end else if (cmdStrobe) begin
            linkCodeReg <= cmdCode;
            linkAddrReg <= cmdAddr;
            linkDataReg <= cmdData;
        end
    end

    // Pins and the command toggle all cross through the same filter
    input_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({linkToggleReg, sharedPinIn}),
        .stable  (syncStable)
    );

    // A changed toggle marks exactly one new command
    always_ff @(posedge clk) begin
        if (rst) begin
            togglePrevReg <= 1'b0;
        end else begin
            togglePrevReg <= syncStable[`SYNC_TOGGLE];
        end
    end

    assign newCmd  = syncStable[`SYNC_TOGGLE] != togglePrevReg;
    assign cmdCls  = classify(linkCodeReg);
    assign bpLevel = statusBitsReg[`ST_BP_HI-`ST_BP_LO:0];
    assign quadOn  = statusBitsReg[`ST_QUAD-`ST_BP_LO];

    // The protect pin only means something while it is not a data line
    assign statusLocked = statusBitsReg[`ST_SWD-`ST_BP_LO] & ~quadOn
                        & ~syncStable[`PIN_WP];

    // Block lookup for the addressed target
    protect_decode u_decode (
        .level     (bpLevel),
        .bottomSel (funcReg[`FN_TB]),
        .map256    (map256Reg),
        .addr      (linkAddrReg),
        .hit       (targetHit)
    );

    // Admission of program and erase requests
    assign isArrayErase = (linkCodeReg == `OP_ARRAY_ERASE)
                        || (linkCodeReg == `OP_ARRAY_ERASE_ALT);
    assign bpAllZero    = bpLevel == `LVL_NONE;
    assign opBlocked    = isArrayErase ? ~bpAllZero : targetHit;
    assign opAllowed    = wrLatchReg & ~arrayBusy & ~opBlocked;

    // Write enable latch: set and reset by its own commands, spent by any write but the two latch-free volatile ones
    always_ff @(posedge clk) begin
        if (rst) begin
            wrLatchReg <= 1'b0;
        end else if (newCmd) begin
            if (cmdCls == CLS_LATCH) begin
                wrLatchReg <= linkCodeReg == `OP_WR_ENABLE;
            end else if (cmdCls == CLS_STATUS || cmdCls == CLS_FUNC
                         || cmdCls == CLS_ARRAY) begin
                wrLatchReg <= 1'b0;
            end else if (cmdCls == CLS_VOLREG && (linkCodeReg == `OP_RDPARAM_VOL
                         || linkCodeReg == `OP_BANK_VOL)) begin
                wrLatchReg <= 1'b0;
            end
        end
    end

    // Protect, quad and disable bits; reachable only by the status write
    always_ff @(posedge clk) begin
        if (rst) begin
            statusBitsReg <= `ST_RESET;
        end else if (newCmd && cmdCls == CLS_STATUS && wrLatchReg && !statusLocked) begin
            statusBitsReg <= linkDataReg[`ST_SWD:`ST_BP_LO];
        end
    end

    // Function byte: one-time bits only ever gain ones, suspend flags are hardware owned
    always_ff @(posedge clk) begin
        if (rst) begin
            funcReg             <= `FN_RESET;
            funcReg[`FN_RSTDIS] <= RST_DIS_DEFAULT;
        end else if (newCmd) begin
            if (cmdCls == CLS_FUNC && wrLatchReg) begin
                funcReg <= funcReg | (linkDataReg & `FN_OTP_MASK);
            end else if (cmdCls == CLS_SUSPEND) begin
                if (linkCodeReg == `OP_SUSPEND && arrayBusy) begin
                    funcReg[`FN_ESUSP] <= arrayOpErase;
                    funcReg[`FN_PSUSP] <= ~arrayOpErase;
                end else if (linkCodeReg == `OP_RESUME) begin
                    funcReg[`FN_ESUSP] <= 1'b0;
                    funcReg[`FN_PSUSP] <= 1'b0;
                end
            end
        end
    end

    // Volatile read parameters and bank address
    always_ff @(posedge clk) begin
        if (rst) begin
            readParamsReg <= 8'h00;
            bankAddrReg   <= 8'h00;
        end else if (newCmd && cmdCls == CLS_VOLREG) begin
            if (linkCodeReg == `OP_RDPARAM_VOL_FREE) begin
                readParamsReg <= linkDataReg;
            end else if (linkCodeReg == `OP_BANK_VOL_FREE) begin
                bankAddrReg <= linkDataReg;
            end else if (wrLatchReg && linkCodeReg == `OP_RDPARAM_VOL) begin
                readParamsReg <= linkDataReg;
            end else if (wrLatchReg && linkCodeReg == `OP_BANK_VOL) begin
                bankAddrReg <= linkDataReg;
            end
        end
    end

    // Start or refuse array work; a refused target is never handed on
    always_ff @(posedge clk) begin
        if (rst) begin
            arrayOpStart <= 1'b0;
            opRefused    <= 1'b0;
            arrayOpErase <= 1'b0;
            arrayOpAddr  <= 26'h000_0000;
        end else begin
            arrayOpStart <= newCmd && cmdCls == CLS_ARRAY && opAllowed;
            opRefused    <= newCmd && cmdCls == CLS_ARRAY && wrLatchReg
                            && !arrayBusy && opBlocked;
            if (newCmd && cmdCls == CLS_ARRAY && opAllowed) begin
                arrayOpErase <= (linkCodeReg != `OP_PAGE_PROG)
                                && (linkCodeReg != `OP_PAGE_PROG4);
                arrayOpAddr  <= linkAddrReg;
            end
        end
    end

    // Refusal counter saturates so software can tell it overflowed
    always_ff @(posedge clk) begin
        if (rst) begin
            refusedCountReg <= 8'h00;
        end else if (opRefused && refusedCountReg != 8'hFF) begin
            refusedCountReg <= refusedCountReg + 8'h01;
        end
    end

    // Shared pins: inputs while quad is off, data lines while on
    always_ff @(posedge clk) begin
        if (rst) begin
            sharedPinOut <= 2'h0;
            sharedPinOe  <= 2'h0;
            quadDataIn   <= 2'h0;
            holdAsserted <= 1'b0;
        end else begin
            sharedPinOut <= quadDataOut;
            sharedPinOe  <= quadOn ? quadDriveEn : 2'h0;
            quadDataIn   <= quadOn ? syncStable[`PIN_HOLD:`PIN_WP] : 2'h0;
            holdAsserted <= ~quadOn & ~syncStable[`PIN_HOLD];
        end
    end

    // Wishbone slave: one wait state; a write lands on the edge that sees ack
    assign busReq   = wbCyc & wbStb;
    assign busWrite = busReq & wbWe & wbAck;

    always_ff @(posedge clk) begin
        if (rst) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= busReq & ~wbAck;
        end
    end

    // Read data is registered with the ack
    always_ff @(posedge clk) begin
        if (rst) begin
            wbDatR <= `DATA_ZERO;
        end else if (busReq && !wbAck && !wbWe) begin
            wbDatR <= readMux(wbAdr);
        end
    end

    // Control register: block map size
    always_ff @(posedge clk) begin
        if (rst) begin
            map256Reg <= 1'b0;
        end else if (busWrite && wbSel[0] && {wbAdr[4:2], `WORD_PAD} == `REG_CTRL) begin
            map256Reg <= wbDatW[`CTRL_MAP256];
        end
    end

endmodule // flash_write_protection
`default_nettype wire

// [fwp_defines.svh]
// Named constants of the flash write-protection block
`ifndef FWP_DEFINES_SVH
`define FWP_DEFINES_SVH

// Command opcodes seen on the link
`define OP_WR_ENABLE        8'h06
`define OP_WR_DISABLE       8'h04
`define OP_STATUS_WR        8'h01
`define OP_FUNC_WR          8'h42
`define OP_RDPARAM_VOL_FREE 8'hC0
`define OP_RDPARAM_VOL      8'h63
`define OP_BANK_VOL_FREE    8'h17
`define OP_BANK_VOL         8'hC5
`define OP_PAGE_PROG        8'h02
`define OP_PAGE_PROG4       8'h12
`define OP_SECT_ERASE       8'h20
`define OP_SECT_ERASE_ALT   8'hD7
`define OP_BLOCK_ERASE      8'hD8
`define OP_ARRAY_ERASE      8'hC7
`define OP_ARRAY_ERASE_ALT  8'h60
`define OP_SUSPEND          8'h75
`define OP_RESUME           8'h7A

// Status byte fields
`define ST_BUSY     0
`define ST_WR_LATCH 1
`define ST_BP_LO    2
`define ST_BP_HI    5
`define ST_QUAD     6
`define ST_SWD      7
`define ST_RESET    6'h00

// Function byte fields
`define FN_RSTDIS   0
`define FN_TB       1
`define FN_PSUSP    2
`define FN_ESUSP    3
`define FN_IRL_LO   4
`define FN_IRL_HI   7
`define FN_OTP_MASK 8'hF3
`define FN_RESET    8'h00

// Wishbone byte offsets and control fields
`define REG_STATUS  5'h00
`define REG_FUNC    5'h04
`define REG_CTRL    5'h08
`define REG_PARAMS  5'h0C
`define REG_REFUSED 5'h10
`define CTRL_MAP256 0
`define WORD_PAD    2'b00
`define DATA_ZERO   32'h0000_0000

// Address fields that select a block
`define ADDR_HI     25
`define BLK64_LO    16
`define BLK256_LO   18

// Protection level decode
`define LVL_NONE    4'h0
`define LVL_STEP    4'h1
`define LVL_MAX256  4'h8
`define LVL_L10     4'hA
`define LVL_L11     4'hB
`define LVL_L12     4'hC
`define LVL_L13     4'hD
`define LVL_L14     4'hE
`define LVL_L15     4'hF
`define CNT_NONE    11'h000
`define CNT_ONE     11'h001
`define CNT_L10     11'h200
`define CNT_L11     11'h300
`define CNT_L12     11'h380
`define CNT_L13     11'h3C0
`define CNT_L14     11'h3E0
`define CNT_L15     11'h400
`define BLOCKS64    11'h400
`define BLOCKS256   11'h100

// Synchroniser lanes: write-protect pin, hold pin, command toggle
`define SYNC_W      3
`define PIN_WP      0
`define PIN_HOLD    1
`define SYNC_TOGGLE 2
`define SYNC_RESET  3'h3

`endif

// [fwp_pkg.sv]
// Types shared by the flash write-protection block
`default_nettype none
package fwp_pkg;
    typedef logic [3:0] bp_level_t;

    // Command class, one-hot
    typedef enum logic [6:0] {
        CLS_IGNORE  = 7'b000_0001,
        CLS_LATCH   = 7'b000_0010,
        CLS_STATUS  = 7'b000_0100,
        CLS_FUNC    = 7'b000_1000,
        CLS_VOLREG  = 7'b001_0000,
        CLS_ARRAY   = 7'b010_0000,
        CLS_SUSPEND = 7'b100_0000
    } cmd_class_t;
endpackage
`default_nettype wire

// [input_sync.sv]
// Three-stage synchroniser with agreement filter for foreign inputs
`include "fwp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module input_sync (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Raw and filtered levels
    input  wire logic [`SYNC_W-1:0] asyncIn,
    output logic      [`SYNC_W-1:0] stable
);
    logic [`SYNC_W-1:0] stage1Reg;
    logic [`SYNC_W-1:0] stage2Reg;
    logic [`SYNC_W-1:0] stage3Reg;
    logic [`SYNC_W-1:0] stableReg;
    localparam logic [`SYNC_W-1:0] RESET_VAL = `SYNC_RESET;

    genvar i;
    generate
        for (i = 0; i < `SYNC_W; i++) begin : g_lane
            // Stage one feeds only stage two; a change counts once two and three agree
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1Reg[i] <= RESET_VAL[i];
                    stage2Reg[i] <= RESET_VAL[i];
                    stage3Reg[i] <= RESET_VAL[i];
                    stableReg[i] <= RESET_VAL[i];
                end else begin
                    stage1Reg[i] <= asyncIn[i];
                    stage2Reg[i] <= stage1Reg[i];
                    stage3Reg[i] <= stage2Reg[i];
                    if (stage2Reg[i] == stage3Reg[i]) begin
                        stableReg[i] <= stage3Reg[i];
                    end
                end
            end
        end
    endgenerate

    assign stable = stableReg;
endmodule // input_sync
`default_nettype wire

// [protect_decode.sv]
// Decodes the protection level into a hit on the addressed block
`include "fwp_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module protect_decode
    import fwp_pkg::*;
(
    // Protection setting
    input  wire bp_level_t    level,
    input  wire logic         bottomSel,
    input  wire logic         map256,
    // Target address and result
    input  wire logic [25:0]  addr,
    output logic              hit
);
    logic [10:0] count;
    logic [10:0] total;
    logic [10:0] blockIdx;

    // Number of protected blocks for a level in either map
    function automatic logic [10:0] blocksFor(input bp_level_t lvl, input logic big);
        logic [10:0] n;
        n = `CNT_NONE;
        if (lvl == `LVL_NONE) begin
            n = `CNT_NONE;
        end else if (big && lvl > `LVL_MAX256) begin
            n = `BLOCKS256;
        end else begin
            case (lvl)
                `LVL_L10: n = `CNT_L10;
                `LVL_L11: n = `CNT_L11;
                `LVL_L12: n = `CNT_L12;
                `LVL_L13: n = `CNT_L13;
                `LVL_L14: n = `CNT_L14;
                `LVL_L15: n = `CNT_L15;
                default:  n = 11'(`CNT_ONE << (lvl - `LVL_STEP));
            endcase
        end
        return n;
    endfunction

    // Top region ends at the last block, bottom region starts at block zero
    always_comb begin
        count    = blocksFor(level, map256);
        total    = map256 ? `BLOCKS256 : `BLOCKS64;
        blockIdx = map256 ? 11'(addr[`ADDR_HI:`BLK256_LO]) : 11'(addr[`ADDR_HI:`BLK64_LO]);
        if (count == `CNT_NONE) begin
            hit = 1'b0;
        end else if (bottomSel) begin
            hit = blockIdx < count;
        end else begin
            hit = blockIdx >= (total - count);
        end
    end
endmodule // protect_decode
`default_nettype wire

// [fwp_properties.sv]
// Port checker for the flash write-protection block
`timescale 1ns/100ps
`default_nettype none
module fwp_properties (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus answer
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbAck,
    input wire logic [31:0] wbDatR,
    // Shared pins
    input wire logic [1:0]  sharedPinOe,
    input wire logic [1:0]  quadDataIn,
    input wire logic        holdAsserted,
    // Array engine
    input wire logic        arrayOpStart,
    input wire logic [25:0] arrayOpAddr,
    input wire logic        opRefused
);
    // Everything here lives in the system clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Bus request taken, then a one-cycle answer
    sequence s_take;
        wbCyc && wbStb && !wbAck;
    endsequence
    sequence s_answer;
        wbAck ##1 !wbAck;
    endsequence
    property p_ack_next;
        s_take |=> s_answer;
    endproperty
    property p_ack_cause;
        wbAck |-> $past(wbCyc) && $past(wbStb);
    endproperty
    property p_dat_hold;
        !wbAck |-> $stable(wbDatR);
    endproperty
    // Accept and refuse are exclusive single pulses
    property p_excl;
        opRefused |-> !arrayOpStart;
    endproperty
    property p_start_pulse;
        arrayOpStart |=> !arrayOpStart;
    endproperty
    property p_ref_pulse;
        opRefused |=> !opRefused;
    endproperty
    // Pin role: hold only as an input, never while driving data
    property p_hold_role;
        holdAsserted |-> sharedPinOe == 2'b00;
    endproperty
    property p_quad_in;
        holdAsserted |-> quadDataIn == 2'b00;
    endproperty
    // Target address moves only with an accepted operation
    property p_addr_hold;
        !arrayOpStart |-> $stable(arrayOpAddr);
    endproperty

    a_ack_next: assert property (p_ack_next) else $error("bus answer late or long");
    a_ack_cause: assert property (p_ack_cause) else $error("bus answer without request");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without answer");
    a_excl: assert property (p_excl) else $error("accept and refuse together");
    a_start_pulse: assert property (p_start_pulse) else $error("accept pulse long");
    a_ref_pulse: assert property (p_ref_pulse) else $error("refuse pulse long");
    a_hold_role: assert property (p_hold_role) else $error("hold while driving");
    a_quad_in: assert property (p_quad_in) else $error("data seen in pin mode");
    a_addr_hold: assert property (p_addr_hold) else $error("target moved");
endmodule // fwp_properties

bind flash_write_protection fwp_properties chk (.clk, .rst, .wbCyc, .wbStb, .wbAck, .wbDatR,
    .sharedPinOe, .quadDataIn, .holdAsserted, .arrayOpStart, .arrayOpAddr, .opRefused);
`default_nettype wire

// [host_link.sv]
// Host controller model driving decoded commands on the link clock
`timescale 1ns/100ps
`default_nettype none
module host_link (
    // Decoded command link
    output logic        serialClk,
    output logic        cmdStrobe,
    output logic [7:0]  cmdCode,
    output logic [25:0] cmdAddr,
    output logic [7:0]  cmdData
);
    // Idle: clock stopped low, fields parked
    initial begin
        serialClk = 1'b0;
        cmdStrobe = 1'b0;
        cmdCode = 8'h04;
        cmdAddr = 26'h0;
        cmdData = 8'h00;
    end

    // Four link periods per frame keep strobes apart
    // Status bits change only through the status write opcode
    // Pins are never tied to a rail here, so quad may be raised
    task automatic send(input logic [7:0] c, input logic [25:0] a, input logic [7:0] d);
        cmdCode = c;
        cmdAddr = a;
        cmdData = d;
        cmdStrobe <= 1'b1;
        repeat (4) begin
            #24 serialClk = 1'b1;
            cmdStrobe <= 1'b0;
            #24 serialClk = 1'b0;
        end
    endtask
endmodule // host_link
`default_nettype wire

// [tb_top.sv]
// Bench for the flash write-protection block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // Stimulus and observed outputs
    logic        clk = 1'b0, rst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [4:0]  wbAdr = 5'h00;
    logic [3:0]  wbSel = 4'h1;
    logic [31:0] wbDatW = 32'h0, wbDatR, q;
    logic        serialClk, cmdStrobe, holdAsserted, arrayBusy = 1'b0;
    logic [7:0]  cmdCode, cmdData;
    logic [25:0] cmdAddr, arrayOpAddr;
    logic [1:0]  sharedPinIn = 2'b11, sharedPinOut, sharedPinOe, quadDataIn;
    logic [1:0]  quadDataOut = 2'b10, quadDriveEn = 2'b11;
    logic        arrayOpStart, arrayOpErase, opRefused;
    int          err_total = 0, cmp_count = 0, nStart = 0, nRef = 0;

    always #5 clk = ~clk;

    flash_write_protection dut (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW,
        .wbAck, .wbDatR, .serialClk, .cmdStrobe, .cmdCode, .cmdAddr, .cmdData, .sharedPinIn,
        .sharedPinOut, .sharedPinOe, .quadDataOut, .quadDriveEn, .quadDataIn, .holdAsserted,
        .arrayBusy, .arrayOpStart, .arrayOpErase, .arrayOpAddr, .opRefused);
    host_link link (.serialClk, .cmdStrobe, .cmdCode, .cmdAddr, .cmdData);

    // Pulses counted from settled pre-edge values
    always @(posedge clk) begin
        nStart += (arrayOpStart === 1'b1);
        nRef += (opRefused === 1'b1);
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Classic cycle: hold until ack at an edge, then one idle cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatW <= d;
        do @(posedge clk); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask
    // Effects land within six clocks of the strobe; the frame outlasts that
    task automatic cmd(input logic [7:0] c, input logic [25:0] a, input logic [7:0] d);
        link.send(c, a, d);
        repeat (4) @(posedge clk);
    endtask
    task automatic setst(input logic [7:0] s);
        cmd(8'h06, 26'h0, 8'h00);
        cmd(8'h01, 26'h0, s);
    endtask
    // Write-enabled array operation; k masks which pulses are judged
    task automatic op(input logic [7:0] c, input logic [25:0] a, input logic [1:0] e,
                      input logic [1:0] k);
        int s0, r0;
        s0 = nStart;
        r0 = nRef;
        cmd(8'h06, 26'h0, 8'h00);
        cmd(c, a, 8'h00);
        check({30'h0, {nStart != s0, nRef != r0} & k}, {30'h0, e}); // Outcome
        if (e[1])
            check({6'h0, arrayOpAddr}, {6'h0, a}); // Target
    endtask
    function automatic int cnt(input int l, input logic m);
        if (l == 0) return 0;
        if (m) return l > 8 ? 256 : 1 << (l - 1);
        if (l == 15) return 1024;
        return l > 10 ? 1024 - (1024 >> (l - 9)) : 1 << (l - 1);
    endfunction

    // Blocks just inside and just outside the region, every level
    task automatic scan(input logic m, input logic b);
        int l, c, n, s;
        n = m ? 256 : 1024;
        s = m ? 18 : 16;
        wb(1'b1, 5'h08, {31'h0, m});
        for (l = 0; l < 16; l++) begin
            c = cnt(l, m); // Size
            setst({2'b00, 4'(l), 2'b00});
            if (c > 0) op(8'hD8, 26'(b ? c - 1 : n - c) << s, 2'b01, 2'b11);
            if (c < n) op(8'hD8, 26'(b ? c : n - c - 1) << s, 2'b10, 2'b11); // Out
        end
    endtask
    task automatic t_reset;
        wb(1'b1, 5'h04, 32'h0000_00FF);
        wb(1'b1, 5'h14, 32'h0000_00FF);
        wb(1'b0, 5'h04, 32'h0);
        check(q, 32'h0); // Function byte
        wb(1'b0, 5'h14, 32'h0);
        check(q, 32'h0); // Unmapped
        wb(1'b0, 5'h00, 32'h0);
        check(q, 32'h0); // Status
    endtask
    task automatic t_vol;
        cmd(8'h04, 26'h0, 8'h00);
        cmd(8'hC0, 26'h0, 8'h5A);
        cmd(8'h17, 26'h0, 8'h3C);
        cmd(8'h63, 26'h0, 8'h11);
        wb(1'b0, 5'h0C, 32'h0);
        check(q, 32'h0000_3C5A); // Volatile bytes
    endtask
    task automatic t_lock;
        setst(8'h80);
        sharedPinIn <= 2'b10;
        setst(8'h14);
        wb(1'b0, 5'h00, 32'h0);
        check(q, 32'h0000_0080); // Frozen
        sharedPinIn <= 2'b11;
        setst(8'h14);
        wb(1'b0, 5'h00, 32'h0);
        check(q, 32'h0000_0014); // Written
    endtask
    task automatic t_quad;
        sharedPinIn <= 2'b01;
        repeat (8) @(posedge clk);
        check({29'h0, holdAsserted, sharedPinOe}, 32'h4); // Pin mode
        sharedPinIn <= 2'b11;
        setst(8'h40);
        sharedPinIn <= 2'b01;
        repeat (8) @(posedge clk);
        check({25'h0, holdAsserted, quadDataIn, sharedPinOe, sharedPinOut}, 32'h1E);
        sharedPinIn <= 2'b11;
        setst(8'h00);
    endtask
    // Level 8 sets only the top bit, level 1 only the bottom one
    task automatic t_array;
        for (int i = 0; i < 2; i++) begin
            setst(i ? 8'h04 : 8'h20);
            op(i ? 8'h60 : 8'hC7, 26'h0, 2'b00, 2'b10); // Not started
            setst(8'h00);
            op(i ? 8'h60 : 8'hC7, 26'h0, 2'b10, 2'b11); // Started
            check({31'h0, arrayOpErase}, 32'h1); // Erase kind
        end
    endtask
    task automatic t_otp;
        cmd(8'h06, 26'h0, 8'h00);
        cmd(8'h42, 26'h0, 8'hF3);
        cmd(8'h06, 26'h0, 8'h00);
        cmd(8'h42, 26'h0, 8'h00);
        wb(1'b0, 5'h04, 32'h0);
        check(q, 32'h0000_00F3); // Kept set
    endtask
    task automatic t_susp;
        wb(1'b0, 5'h10, 32'h0);
        check(q, 32'h0000_002F); // Refusals
        setst(8'h00);
        for (int i = 0; i < 2; i++) begin
            op(i ? 8'hD8 : 8'h02, 26'h0, 2'b10, 2'b11);
            arrayBusy <= 1'b1;
            cmd(8'h75, 26'h0, 8'h00);
            wb(1'b0, 5'h04, 32'h0);
            check(q, i ? 32'h0000_00FB : 32'h0000_00F7); // Suspended
            cmd(8'h7A, 26'h0, 8'h00);
            wb(1'b0, 5'h04, 32'h0);
            check(q, 32'h0000_00F3); // Resumed
            arrayBusy <= 1'b0;
        end
    endtask

    // Link edges during reset so its side resets too
    initial begin
        fork
            #1 link.send(8'h04, 26'h0, 8'h00);
        join_none
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_vol();
        t_lock();
        t_quad();
        t_array();
        scan(1'b0, 1'b0);
        scan(1'b1, 1'b0);
        t_otp();
        scan(1'b0, 1'b1);
        t_susp();
        test_done();
    end
    // Watchdog
    initial begin
        #500_000;
        err_total++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
